/* File: rtl/cia_channel_irq.sv */
// Behaviour
// R1 - Pending bits per channel in two status registers.
// R2 - Pending bit shows an interrupt awaits service.
// R3 - Pending holds until source status is read.
// R4 - Host writes never change pending bits.
// R5 - Host reads source status to find cause.
// R6 - Read/write master enables, channels six to eleven.
// R7 - Cleared master enable blocks the channel's interrupt.
// R8 - Set master enable passes enabled source interrupts.
// R9 - Host must also enable interrupts at source.
// R10 - Master enables for channels zero to five.
// R11 - Interrupt output follows any enabled pending channel.
// R12 - Bits seven and six read zero, ignore writes.
`timescale 1ns/10ps
`default_nettype none

module cia_channel_irq #(
    parameter int unsigned NUM_CH = cia_pkg::NUM_CHANNELS
) (
    input  wire logic              i_clk,            // System clock.
    input  wire logic              i_rst_n,          // Async reset, low.
    input  wire logic              i_ce,             // Clock enable.
    input  wire logic              psel,             // APB select.
    input  wire logic              penable,          // APB access phase.
    input  wire logic              pwrite,           // APB write.
    input  wire logic [11:0]       paddr,            // APB byte address.
    input  wire logic [31:0]       pwdata,           // APB write data.
    input  wire logic [3:0]        pstrb,            // APB byte strobes.
    output logic                   pready,           // APB ready.
    output logic [31:0]            prdata,           // APB read data.
    output logic                   pslverr,          // APB error.
    input  wire logic [NUM_CH-1:0] i_src_irq,        // Enabled source events.
    input  wire logic [NUM_CH-1:0] i_src_status_rd,  // Source status read.
    output logic                   o_irq             // Host interrupt.
);

    // The register map holds exactly two groups of six channels.
    if (NUM_CH != cia_pkg::NUM_CHANNELS) begin : g_bad_num_ch
        $error("NUM_CH must be twelve for this register map.");
    end

    typedef struct packed {
        logic [NUM_CH-1:0] pending;
        logic [NUM_CH-1:0] enable;
        logic              ready;
        logic [31:0]       rdata;
        logic              slverr;
        logic              irq;
    } cia_state_t;

    cia_state_t st;
    cia_state_t next_st;

    logic [7:0] reg_idx;
    logic       addr_ok;
    logic       hit_en_lo;
    logic       hit_pn_lo;
    logic       hit_en_hi;
    logic       hit_pn_hi;
    logic       mapped;
    logic       access;

    assign reg_idx   = paddr[9:2];
    assign addr_ok   = (paddr[1:0] == cia_pkg::BYTE_OFFSET_ZERO)
                       && (paddr[11:10] == 2'h0);
    assign hit_en_lo = addr_ok && (reg_idx == cia_pkg::IDX_ENABLE_LOW);
    assign hit_pn_lo = addr_ok && (reg_idx == cia_pkg::IDX_PENDING_LOW);
    assign hit_en_hi = addr_ok && (reg_idx == cia_pkg::IDX_ENABLE_HIGH);
    assign hit_pn_hi = addr_ok && (reg_idx == cia_pkg::IDX_PENDING_HIGH);
    assign mapped    = hit_en_lo || hit_pn_lo || hit_en_hi || hit_pn_hi;
    // One wait state: the access phase completes when pready is registered.
    assign access    = psel && penable && !st.ready;

    always_comb begin
        next_st        = st;
        next_st.ready  = 1'b0;
        next_st.slverr = 1'b0;
        // A new event wins over the clear from a source status read.
        next_st.pending = (st.pending & ~i_src_status_rd) | i_src_irq; // R3
        if (access) begin
            next_st.ready  = 1'b1;
            next_st.slverr = !mapped;
            next_st.rdata  = cia_pkg::READ_ZERO;
            if (pwrite) begin
                // Pending registers ignore writes; only bits 5..0 store.
                if (hit_en_lo && pstrb[0]) begin
                    next_st.enable[5:0] = pwdata[5:0]; // R10 R12
                end
                if (hit_en_hi && pstrb[0]) begin
                    next_st.enable[11:6] = pwdata[5:0]; // R6 R12
                end
            end else begin
                unique case (1'b1)
                    hit_en_lo: next_st.rdata[5:0] = st.enable[5:0]; // R10
                    hit_pn_lo: next_st.rdata[5:0] = st.pending[5:0]; // R1 R2
                    hit_en_hi: next_st.rdata[5:0] = st.enable[11:6]; // R6
                    hit_pn_hi: next_st.rdata[5:0] = st.pending[11:6]; // R1
                    default:   next_st.rdata[5:0] = cia_pkg::FIELD_ZERO;
                endcase
            end
        end
        // Pending bits accumulate whatever the master enable says.
        next_st.irq = |(next_st.pending & next_st.enable); // R7 R8 R11
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st.pending <= cia_pkg::CHANNELS_ZERO;
            st.enable  <= {cia_pkg::ENABLE_RESET, cia_pkg::ENABLE_RESET};
            st.ready   <= 1'b0;
            st.rdata   <= cia_pkg::READ_ZERO;
            st.slverr  <= 1'b0;
            st.irq     <= 1'b0;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign pready  = st.ready;
    assign prdata  = st.rdata;
    assign pslverr = st.slverr;
    assign o_irq   = st.irq;

    a_pending_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && $past(i_ce) && $past(st.pending[0])
        && !$past(i_src_status_rd[0]) |-> st.pending[0]) // R3
        else $error("Pending bit dropped without source read.");
    a_pending_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_src_irq[7] |=> !i_ce || st.pending[7]) // R2
        else $error("Event did not set pending bit.");
    a_write_ignored: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && access && pwrite && hit_pn_lo && i_src_irq == '0
        && i_src_status_rd == '0 |=> !i_ce || $stable(st.pending)) // R4
        else $error("Write changed pending bits.");
    a_enable_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && access && pwrite && hit_en_hi && pstrb[0]
        |=> !i_ce || st.enable[11:6] == $past(pwdata[5:0])) // R6
        else $error("High enable write not stored.");
    a_enable_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && access && pwrite && hit_en_lo && pstrb[0]
        |=> !i_ce || st.enable[5:0] == $past(pwdata[5:0])) // R10
        else $error("Low enable write not stored.");
    a_irq_blocked: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (st.pending & st.enable) == '0 |-> !o_irq) // R7
        else $error("Interrupt raised by disabled channel.");
    a_irq_raised: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (st.pending & st.enable) != '0 |-> o_irq) // R8 R11
        else $error("Interrupt missing for enabled pending channel.");
    a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        pready |-> prdata[31:6] == '0) // R12
        else $error("Reserved read bits not zero.");
    a_read_pending: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && access && !pwrite && hit_pn_hi
        |=> !i_ce || prdata[5:0] == $past(st.pending[11:6])) // R1
        else $error("High pending read wrong.");

    a_read_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && access && !pwrite && hit_pn_lo
        |=> prdata[5:0] == $past(st.pending[5:0])) // R1
        else $error("Low pending read wrong.");
    a_read_en_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && access && !pwrite && hit_en_hi
        |=> prdata[5:0] == $past(st.enable[11:6])) // R6
        else $error("High enable read wrong.");
    a_read_en_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && access && !pwrite && hit_en_lo
        |=> prdata[5:0] == $past(st.enable[5:0])) // R10
        else $error("Low enable read wrong.");
    a_ready_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && access |=> pready)
        else $error("Access phase not answered after one wait state.");
    a_ready_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && pready |=> !pready)
        else $error("Ready stood longer than one cycle.");
    a_slverr_unmapped: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        i_ce && access && !mapped |=> pslverr)
        else $error("Unmapped access not flagged.");
    a_err_with_ready: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        pslverr |-> pready)
        else $error("Error response without ready.");
    a_unmapped_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && access && pwrite && !mapped |=> $stable(st.enable))
        else $error("Unmapped write changed an enable.");
    a_strobe_masked: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && access && pwrite && !pstrb[0] |=> $stable(st.enable))
        else $error("Write without low strobe changed an enable.");
    a_unmapped_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && access && !pwrite && !mapped |=> prdata == '0)
        else $error("Unmapped read returned data.");
    a_freeze_all: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_ce |=> $stable(st))
        else $error("State moved while the clock enable was low.");

    // Per-channel checks of the pending flag and its path to the output.
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan_check
        a_chan_hold: assert property (@(posedge i_clk)
            disable iff (!i_rst_n)
            i_ce && st.pending[ch] && !i_src_status_rd[ch]
            |=> st.pending[ch]) // R3
            else $error("Pending bit lost before its source read.");
        a_chan_set: assert property (@(posedge i_clk)
            disable iff (!i_rst_n)
            i_ce && i_src_irq[ch] |=> st.pending[ch]) // R2
            else $error("Source event did not set its pending bit.");
        a_chan_clear: assert property (@(posedge i_clk)
            disable iff (!i_rst_n)
            i_ce && i_src_status_rd[ch] && !i_src_irq[ch]
            |=> !st.pending[ch]) // R3
            else $error("Source read did not clear its pending bit.");
        a_chan_irq: assert property (@(posedge i_clk)
            disable iff (!i_rst_n)
            st.pending[ch] && st.enable[ch] |-> o_irq) // R8
            else $error("Enabled pending channel gave no interrupt.");
        a_chan_readonly: assert property (@(posedge i_clk)
            disable iff (!i_rst_n)
            i_ce && access && pwrite && (hit_pn_lo || hit_pn_hi)
            && !i_src_irq[ch] && !i_src_status_rd[ch]
            |=> st.pending[ch] == $past(st.pending[ch])) // R4
            else $error("Write to a pending register moved a bit.");
    end

    c_irq_rise: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        !o_irq ##1 o_irq);
    c_irq_clear: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        o_irq ##1 !o_irq);
    c_read_pend: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        access && !pwrite && hit_pn_lo);
    c_set_clear: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        i_src_irq[0] && i_src_status_rd[0]);
    c_unmapped: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        access && !mapped);

endmodule // cia_channel_irq

`default_nettype wire

/* File: rtl/cia_pkg.sv */
package cia_pkg;

    localparam int unsigned NUM_CHANNELS     = 12;
    localparam int unsigned CHANNELS_PER_REG = 6;
    localparam int unsigned APB_ADDR_W       = 12;

    // Printed offsets are register indices; byte address is four times it.
    localparam logic [7:0] IDX_ENABLE_LOW   = 8'h60;
    localparam logic [7:0] IDX_PENDING_LOW  = 8'h61;
    localparam logic [7:0] IDX_ENABLE_HIGH  = 8'hE0;
    localparam logic [7:0] IDX_PENDING_HIGH = 8'hE1;

    localparam logic [1:0] BYTE_OFFSET_ZERO = 2'h0;
    localparam logic [5:0] ENABLE_RESET     = 6'h00;
    localparam logic [5:0] FIELD_ZERO       = 6'h00;
    localparam logic [11:0] CHANNELS_ZERO   = 12'h000;
    localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

endpackage

/* File: testbench/cia_src_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cia_src_model (
    input  wire logic        i_clk,     // Clock.
    input  wire logic [11:0] i_raise,   // Causes to raise.
    input  wire logic [11:0] i_ack,     // Source status reads.
    output logic      [11:0] o_src_irq, // Gated source events.
    output logic      [11:0] o_src_rd   // Source read pulses.
);
    logic [11:0] src_en = 12'hFFF;
    always_ff @(posedge i_clk) begin
        o_src_irq <= i_raise & src_en;
        o_src_rd  <= i_ack;
    end
endmodule // cia_src_model
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [11:0] raise = 12'h000;
    logic [11:0] ack = 12'h000;
    logic        pready, pslverr, o_irq, err;
    logic [31:0] prdata, rd;
    logic [11:0] src_irq, src_rd;
    int          fail_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    always #5 i_clk = ~i_clk;
    cia_channel_irq cia_channel_irq_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .i_src_irq(src_irq),
        .i_src_status_rd(src_rd), .o_irq(o_irq));
    cia_src_model cia_src_model_inst (.i_clk(i_clk), .i_raise(raise),
        .i_ack(ack), .o_src_irq(src_irq), .o_src_rd(src_rd));
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // APB transfer; pready, prdata and pslverr are taken as the edge sees them.
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task ev(input logic [11:0] r, input logic [11:0] a);
        @(posedge i_clk);
        raise <= r;
        ack <= a;
        @(posedge i_clk);
        raise <= 12'h000;
        ack <= 12'h000;
        repeat (2) @(posedge i_clk);
    endtask
    task irq(input logic e);
        @(negedge i_clk);
        chk({31'h0, o_irq}, {31'h0, e});
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 2000) begin
            fail_count++;
            stop_test;
        end
    end
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        xfer(1'b0, 12'h180, 32'h0); chk(rd, 32'h0);
        xfer(1'b1, 12'h180, 32'hFF);
        xfer(1'b0, 12'h180, 32'h0); chk(rd, 32'h3F);
        xfer(1'b1, 12'h380, 32'hFFFF_FFFF);
        xfer(1'b0, 12'h380, 32'h0); chk(rd, 32'h3F);
        ev(12'h801, 12'h000); irq(1'b1);
        xfer(1'b1, 12'h184, 32'h3F);
        xfer(1'b0, 12'h184, 32'h0); chk(rd, 32'h01);
        xfer(1'b0, 12'h384, 32'h0); chk(rd, 32'h20);
        xfer(1'b1, 12'h180, 32'h0);
        xfer(1'b1, 12'h380, 32'h0); irq(1'b0);
        xfer(1'b0, 12'h384, 32'h0); chk(rd, 32'h20);
        ev(12'h000, 12'h800);
        xfer(1'b0, 12'h384, 32'h0); chk(rd, 32'h0);
        xfer(1'b1, 12'h380, 32'h20); irq(1'b0);
        ev(12'h800, 12'h000); irq(1'b1);
        ev(12'h000, 12'h800); irq(1'b0);
        xfer(1'b0, 12'h184, 32'h0); chk(rd, 32'h01);
        xfer(1'b0, 12'h188, 32'h0); chk({31'h0, err}, 32'h1);
        stop_test;
    end
endmodule // testbench
`default_nettype wire
